// File: hdl/srec_pkg.sv
// Constants, states and carriers shared by the record loader
package srec_pkg;

	// ----------------------------------------------------------------
	// Character codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_S     = 8'h53;
	localparam logic [7:0] CH_0     = 8'h30;
	localparam logic [7:0] CH_9     = 8'h39;
	localparam logic [7:0] CH_UA    = 8'h41;
	localparam logic [7:0] CH_UF    = 8'h46;
	localparam logic [7:0] CH_LA    = 8'h61;
	localparam logic [7:0] CH_LF    = 8'h66;
	localparam logic [7:0] HEX_TEN  = 8'h0A;

	// ----------------------------------------------------------------
	// Record layout
	// ----------------------------------------------------------------
	localparam logic [3:0] TYPE_DATA  = 4'h1;
	localparam logic [3:0] TYPE_END   = 4'h9;
	localparam logic [7:0] IDX_LEN    = 8'h00;
	localparam logic [7:0] IDX_ADDR_H = 8'h01;
	localparam logic [7:0] IDX_ADDR_L = 8'h02;
	localparam logic [7:0] IDX_DATA   = 8'h03;
	localparam logic [7:0] MIN_LEN    = 8'h03;
	localparam logic [7:0] MAX_LEN    = 8'hFF;
	localparam int         DATA_DEPTH = 252;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HUNT,
		ST_TYPE,
		ST_HEX,
		ST_COMMIT,
		ST_WAIT_RD,
		ST_FLUSH
	} state_e;

	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_cmd_s;

endpackage : srec_pkg

// File: hdl/srecord_loader.sv
// Record loader: parses hex load records and writes or verifies memory
`timescale 1ns/100ps
module srecord_loader #(
	parameter int DEPTH = srec_pkg::DATA_DEPTH
) (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               srst,
	// Control
	input  wire logic               load_start,
	input  wire logic               verify_mode,
	output logic                    busy,
	output logic                    done,
	output logic                    error,
	output logic [15:0]             entry_addr,
	// Character stream
	input  wire logic               char_valid,
	input  wire logic [7:0]         char_data,
	output logic                    char_ready,
	// Memory port
	output logic                    mem_valid,
	output srec_pkg::mem_cmd_s      mem_cmd,
	input  wire logic               mem_ready,
	input  wire logic               mem_rvalid,
	input  wire logic [7:0]         mem_rdata
);
	import srec_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_e      state;
	state_e      next_state;
	logic        have_hi;
	logic [3:0]  hi_nib;
	logic [7:0]  byte_idx;
	logic [7:0]  rec_len;
	logic [3:0]  rec_type;
	logic [7:0]  sum;
	logic [15:0] addr;
	logic        seen_s1;
	logic        vmode;
	logic [7:0]  cidx;
	logic [7:0]  rec_buf [0:DEPTH-1];
	logic        v1;
	mem_cmd_s    ent1;

	// ----------------------------------------------------------------
	// Character decode
	// ----------------------------------------------------------------
	wire       accept    = char_valid & char_ready;
	wire       is_dig    = (char_data >= CH_0) && (char_data <= CH_9);
	wire       is_up     = (char_data >= CH_UA) && (char_data <= CH_UF);
	wire       is_lo     = (char_data >= CH_LA) && (char_data <= CH_LF);
	wire       is_hex    = is_dig | is_up | is_lo;
	wire [7:0] dig_val   = char_data - CH_0;
	wire [7:0] up_val    = char_data - CH_UA + HEX_TEN;
	wire [7:0] lo_val    = char_data - CH_LA + HEX_TEN;
	wire [3:0] nib       = is_dig ? dig_val[3:0] : (is_up ? up_val[3:0] : lo_val[3:0]);
	wire       hex_acc   = accept && (state == ST_HEX) && is_hex;
	wire       bad_char  = accept && (state == ST_HEX) && !is_hex;
	wire       byte_done = hex_acc & have_hi;
	wire [7:0] new_byte  = {hi_nib, nib};
	wire       is_len    = byte_idx == IDX_LEN;
	wire       last_byte = byte_done && !is_len && (byte_idx == rec_len);
	wire [7:0] sum_next  = is_len ? new_byte : 8'(sum + new_byte);
	wire       chk_ok    = (~sum) == new_byte;
	// Records longer than the buffer are refused rather than split
	wire [7:0] len_data  = 8'(new_byte - MIN_LEN);
	wire       bad_len   = byte_done && is_len &&
	                       ((new_byte < MIN_LEN) || (32'(len_data) > DEPTH));
	wire       bad_chk   = last_byte & !chk_ok;
	wire       good_rec  = last_byte & chk_ok;
	wire [7:0] ndata     = 8'(rec_len - MIN_LEN);
	wire [7:0] bidx      = 8'(byte_idx - IDX_DATA);
	wire       is_data   = byte_done && (byte_idx >= IDX_DATA) && !last_byte;
	wire [3:0] type_dig  = dig_val[3:0];
	wire       type_take = is_dig && ((type_dig == TYPE_DATA) ||
	                       ((type_dig == TYPE_END) && seen_s1));

	// ----------------------------------------------------------------
	// Commit path and two-entry buffer
	// ----------------------------------------------------------------
	wire        in_ready  = !v1;
	wire        in_push   = (state == ST_COMMIT) & in_ready;
	wire        pop       = mem_valid & mem_ready;
	wire        last_cmit = (8'(cidx + 8'h01) == ndata);
	wire [7:0]  exp_byte  = rec_buf[cidx];
	wire        mismatch  = (state == ST_WAIT_RD) & mem_rvalid & (mem_rdata != exp_byte);
	wire        err_evt   = bad_char | bad_len | bad_chk | mismatch;
	mem_cmd_s   in_cmd;
	assign in_cmd.write = !vmode;
	assign in_cmd.addr  = 16'(addr + {8'h00, cidx});
	assign in_cmd.data  = exp_byte;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				next_state = ST_IDLE;
			ST_HUNT:
				// Terminators and leading fields are simply not the start char
				if (accept && char_data == CH_S)
					next_state = ST_TYPE;
			ST_TYPE:
				if (accept)
					next_state = type_take ? ST_HEX : ST_HUNT;
			ST_HEX:
				if (bad_char || bad_len || bad_chk)
					next_state = ST_HUNT;
				else if (good_rec && rec_type == TYPE_END)
					next_state = ST_FLUSH;
				else if (good_rec)
					next_state = (ndata == 8'h00) ? ST_HUNT : ST_COMMIT;
			ST_COMMIT:
				if (in_push)
					next_state = vmode ? ST_WAIT_RD : (last_cmit ? ST_HUNT : ST_COMMIT);
			ST_WAIT_RD:
				// One read in flight: verify runs at memory latency, but order is trivial
				if (mismatch)
					next_state = ST_HUNT;
				else if (mem_rvalid)
					next_state = last_cmit ? ST_HUNT : ST_COMMIT;
			ST_FLUSH:
				// Done only once every queued write has left the buffer
				if (!mem_valid && !v1)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
		if (load_start)
			next_state = ST_HUNT;
	end

	wire next_char_ready = (next_state == ST_HUNT) || (next_state == ST_TYPE) ||
	                       (next_state == ST_HEX);
	wire done_evt        = (state == ST_FLUSH) && (next_state == ST_IDLE);

	// ----------------------------------------------------------------
	// Sequencing registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state      <= ST_IDLE;
			char_ready <= 1'b0;
			busy       <= 1'b0;
			done       <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			char_ready <= next_char_ready;
			busy       <= next_state != ST_IDLE;
			done       <= done_evt;
		end
	end

	// ----------------------------------------------------------------
	// Error and mode
	// ----------------------------------------------------------------
	// Error is sticky; a new error in the start cycle still shows
	always_ff @(posedge mclk)
	begin
		if (srst)
			error <= 1'b0;
		else
			error <= err_evt | (error & !load_start);
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			seen_s1 <= 1'b0;
			vmode   <= 1'b0;
		end
		else if (load_start)
		begin
			seen_s1 <= 1'b0;
			vmode   <= verify_mode;
		end
		else if (good_rec && rec_type == TYPE_DATA)
			seen_s1 <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Field assembly
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			have_hi  <= 1'b0;
			hi_nib   <= 4'h0;
			byte_idx <= IDX_LEN;
			rec_type <= 4'h0;
		end
		else if (accept && state == ST_TYPE)
		begin
			rec_type <= type_dig;
			have_hi  <= 1'b0;
			byte_idx <= IDX_LEN;
		end
		else if (hex_acc)
		begin
			have_hi  <= !have_hi;
			hi_nib   <= nib;
			byte_idx <= have_hi ? 8'(byte_idx + 8'h01) : byte_idx;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rec_len <= 8'h00;
			sum     <= 8'h00;
			addr    <= 16'h0000;
		end
		else if (byte_done)
		begin
			sum <= sum_next;
			if (is_len)
				rec_len <= new_byte;
			if (byte_idx == IDX_ADDR_H)
				addr[15:8] <= new_byte;
			if (byte_idx == IDX_ADDR_L)
				addr[7:0] <= new_byte;
		end
	end

	// ----------------------------------------------------------------
	// Record buffer and entry address
	// ----------------------------------------------------------------
	// Record bytes wait here until the checksum proves the record good
	// Nothing reaches memory from a record that later fails its checksum
	always_ff @(posedge mclk)
	begin
		if (is_data)
			rec_buf[bidx] <= new_byte;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			entry_addr <= 16'h0000;
		else if (good_rec && rec_type == TYPE_END)
			entry_addr <= addr;
	end

	// Write mode counts pushes, verify mode counts answers
	always_ff @(posedge mclk)
	begin
		if (srst || state == ST_HEX)
			cidx <= 8'h00;
		else if ((in_push && !vmode) || (state == ST_WAIT_RD && mem_rvalid))
			cidx <= 8'(cidx + 8'h01);
	end

	// ----------------------------------------------------------------
	// Two-entry buffer; head entry drives the memory port directly
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mem_valid <= 1'b0;
			v1        <= 1'b0;
		end
		else if (pop)
		begin
			mem_valid <= v1 | in_push;
			v1        <= 1'b0;
		end
		else if (in_push)
		begin
			mem_valid <= 1'b1;
			v1        <= mem_valid;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mem_cmd <= '0;
			ent1    <= '0;
		end
		else if (pop)
			mem_cmd <= v1 ? ent1 : in_cmd;
		else if (in_push && !mem_valid)
			mem_cmd <= in_cmd;
		else if (in_push)
			ent1 <= in_cmd;
	end

endmodule : srecord_loader

// File: tb/srec_checker.sv
// Port checks for the record loader
`timescale 1ns/100ps
module srec_checker #(parameter int DEPTH = 252) (
	input wire logic mclk, srst, load_start, verify_mode, busy, done, error,
	input wire logic char_valid, char_ready, mem_valid, mem_ready, mem_rvalid,
	input wire logic [15:0] entry_addr,
	input wire logic [7:0] char_data, mem_rdata,
	input wire srec_pkg::mem_cmd_s mem_cmd
);
	logic vmode;
	// Mode only counts as sampled on the start pulse
	always_ff @(posedge mclk)
	begin
		if (load_start)
			vmode <= verify_mode;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_start_busy: assert property (load_start |=> busy)
		else $error("busy not raised");
	a_done_pulse: assert property (done |=> !done)
		else $error("done too long");
	a_done_ends: assert property (done && !load_start |=> !busy && !char_ready)
		else $error("load not ended");
	a_error_sticky: assert property (error && !load_start |=> error)
		else $error("error lost");
	a_cmd_hold: assert property (mem_valid && !mem_ready && !load_start
		|=> mem_valid && $stable(mem_cmd))
		else $error("command changed");
	a_idle_quiet: assert property (!busy |-> !char_ready && !mem_valid)
		else $error("active while idle");
	a_mode_kind: assert property (mem_valid |-> mem_cmd.write != vmode)
		else $error("wrong command kind");
	a_entry_hold: assert property (!busy && !load_start |=> $stable(entry_addr))
		else $error("entry moved");
endmodule : srec_checker

bind srecord_loader srec_checker #(.DEPTH(DEPTH)) chk (.mclk(mclk), .srst(srst),
	.load_start(load_start), .verify_mode(verify_mode), .busy(busy), .done(done),
	.error(error), .char_valid(char_valid), .char_ready(char_ready),
	.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
	.entry_addr(entry_addr), .char_data(char_data), .mem_rdata(mem_rdata),
	.mem_cmd(mem_cmd));

// File: tb/mem_model.sv
// Behavioural memory on the loader's memory port
`timescale 1ns/100ps
module mem_model (
	input wire logic mclk, srst, slow, mem_valid,
	input wire srec_pkg::mem_cmd_s mem_cmd,
	output logic mem_ready, mem_rvalid,
	output logic [7:0] mem_rdata
);
	import srec_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] rd;
	logic [1:0] pend;
	logic tog;
	// Slow mode stalls every other cycle and answers reads late
	assign mem_ready = !slow || tog;
	initial
		foreach (mem[i]) mem[i] = 8'h00;
	always @(posedge mclk)
	begin
		if (srst)
		begin
			tog <= 1'b0;
			pend <= 2'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 8'h00;
		end
		else
		begin
			tog <= ~tog;
			mem_rvalid <= 1'b0;
			// Data toggles every cycle outside the answer pulse
			mem_rdata <= ~mem_rdata;
			if (pend != 2'h0)
				pend <= pend - 2'h1;
			if (pend == 2'h1)
			begin
				mem_rvalid <= 1'b1;
				mem_rdata <= rd;
			end
			if (mem_valid && mem_ready && mem_cmd.write)
				mem[mem_cmd.addr] <= mem_cmd.data;
			if (mem_valid && mem_ready && !mem_cmd.write)
			begin
				rd <= mem[mem_cmd.addr];
				pend <= slow ? 2'h3 : 2'h1;
			end
		end
	end
endmodule : mem_model

// File: tb/tb_top.sv
// Self-checking bench for the record loader
`timescale 1ns/100ps
module tb_top;
	import srec_pkg::*;
	logic mclk, srst, load_start, verify_mode, busy, done, error, char_valid;
	logic char_ready, mem_valid, mem_ready, mem_rvalid, slow;
	logic [15:0] entry_addr, a, ea[$];
	logic [7:0] char_data, mem_rdata, ed[$], d[$], e[$];
	logic [31:0] rnd;
	mem_cmd_s mem_cmd;
	int miscompares, comparisons;
	string body, vbad, tail, t;

	srecord_loader uut (.mclk(mclk), .srst(srst), .load_start(load_start),
		.verify_mode(verify_mode), .busy(busy), .done(done), .error(error),
		.entry_addr(entry_addr), .char_valid(char_valid), .char_data(char_data),
		.char_ready(char_ready), .mem_valid(mem_valid), .mem_cmd(mem_cmd),
		.mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
	mem_model mem (.mclk(mclk), .srst(srst), .slow(slow), .mem_valid(mem_valid),
		.mem_cmd(mem_cmd), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata));

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic string rec(int ty, logic [15:0] ad, logic [7:0] q[$], bit bad);
		logic [7:0] s;
		string r;
		s = 8'(q.size() + 3) + ad[15:8] + ad[7:0];
		r = $sformatf("S%0d%02X%04X", ty, q.size() + 3, ad);
		foreach (q[i])
		begin
			s = s + q[i];
			r = {r, $sformatf("%02X", q[i])};
		end
		s = ~s ^ {7'h00, bad};
		return {r, $sformatf("%02X", s), "\r\n"};
	endfunction : rec

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Start a load, stream the text, wait for the end pulse
	task automatic load(bit mode, string s);
		int n;
		@(posedge mclk);
		load_start <= 1'b1;
		verify_mode <= mode;
		@(posedge mclk);
		load_start <= 1'b0;
		for (int i = 0; i <= s.len(); i++)
		begin
			if (i < s.len())
			begin
				char_valid <= 1'b1;
				char_data <= s[i];
			end
			n = 0;
			do
			begin
				@(posedge mclk);
				n++;
			end while ((i < s.len() ? char_ready : done) !== 1'b1 && n < 5000);
			if (n >= 5000)
			begin
				miscompares++;
				end_of_test();
			end
			if (i == s.len() - 1)
			begin
				char_valid <= 1'b0;
				char_data <= ~char_data;
			end
		end
	endtask : load

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial
	begin
		srst = 1'b1;
		load_start = 1'b0;
		verify_mode = 1'b0;
		char_valid = 1'b0;
		char_data = 8'h00;
		slow = 1'b0;
		rnd = 32'h7A55735C;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		#1 chk({busy, done, error, char_ready, mem_valid}, 0);
		d = '{8'h48, 8'h44, 8'h52};
		// Line number, header, an ignored type and an early end record come before data
		body = {"0042 \r\n", rec(0, 16'h0000, d, 0), rec(2, 16'hF000, d, 0),
			rec(9, 16'h1234, e, 0)};
		for (int k = 0; k < 4; k++)
		begin
			d = {};
			rnd = lfsr(rnd);
			a = 16'(16'h1000 * (k + 1)) + {5'h00, rnd[10:0]};
			repeat (k == 3 ? 28 : k * 3)
			begin
				rnd = lfsr(rnd);
				ea.push_back(a + 16'(d.size()));
				ed.push_back(rnd[7:0]);
				d.push_back(rnd[7:0]);
			end
			t = rec(1, a, d, 0);
			if (k == 2)
				t = {t.substr(0, 1), t.substr(2, t.len() - 1).tolower()};
			body = {body, t};
			if (k == 1)
			begin
				d[0] = d[0] ^ 8'h01;
				vbad = rec(1, a, d, 0);
			end
		end
		a = rnd[31:16];
		// The loader holds off characters once the end record is in: no terminator after it
		t = rec(9, a, e, 0);
		tail = {rec(1, 16'h0100, e, 0), t.substr(0, t.len() - 3)};
		body = {body, tail};
		load(0, body);
		chk(error, 0);
		chk(entry_addr, a);
		foreach (ea[i]) chk(mem.mem[ea[i]], ed[i]);
		chk(mem.mem[16'hF000], 0);
		slow <= 1'b1;
		load(1, body);
		chk(error, 0);
		load(1, {vbad, tail});
		chk(error, 1);
		slow <= 1'b0;
		d = '{8'h55};
		load(0, {rec(1, 16'hE000, d, 1), tail});
		chk(error, 1);
		chk(mem.mem[16'hE000], 0);
		load(0, {"S1040E00G0AA\r\n", tail});
		chk(error, 1);
		load(0, {"S10200FD\r\n", tail});
		chk(error, 1);
		load(0, tail);
		chk(error, 0);
		end_of_test();
	end
endmodule : tb_top
